// File: logic/ddrq_ctrl.sv
// ddr controller: write queue, command sequencer, timing and read capture
// assumes avalon-mm registers on clk_sys and memory pins on the forwarded clock
// Behaviour
// (RULE1) a read waits until every earlier queued write has gone to memory
// (RULE2) self-refresh is entered only with the queue and read slot empty
// (RULE3) after self-refresh exit the queue left behind is executed
// (RULE4) self-refresh exit is sent only while the memory clock runs steadily
// (RULE5) timing word bits 4:7 and 9:11 hold the two activate spacings
// (RULE6) precharge-all precedes refresh; precharge time kept after auto-precharge
// (RULE7) auto-precharge off when burst field non-zero and chip enable bit clear
// (RULE8) receiver enable can rise two cycles early, per cas latency, offset 0x2f00
// (RULE9) the early enable costs gap cycles only on chip select change
// (RULE10) advance register accepts the cl 2 and cl 2.5/3 values
// (RULE11) a new advance value applies from the next read issued
`timescale 1ns/10ps
module ddrq_ctrl #(
	parameter int QD = 8,
	parameter int QAW = 3
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, low
	input wire logic forwarded_memory_clock, // link clock
	input wire logic [15:0] avs_address, // register byte address
	input wire logic avs_read, // register read
	input wire logic avs_write, // register write
	input wire logic [31:0] avs_writedata, // register write data
	input wire logic [3:0] avs_byteenable, // write byte lanes
	output logic [31:0] avs_readdata, // register read data
	output logic avs_waitrequest, // bus stall
	input wire logic req_valid, // request offered
	input wire ddrq_pkg::ddrq_req_type req, // request word
	output logic req_ready, // request taken
	output logic rsp_valid, // read data pulse
	output logic [ddrq_pkg::DW-1:0] rsp_rdata, // read data
	output ddrq_pkg::ddrq_cmd_type mem_cmd, // memory command pins
	output logic mem_rx_en, // data receiver enable
	input wire logic [ddrq_pkg::DW-1:0] mem_dq_i // memory read data
);
	import ddrq_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_WAIT, S_RW, S_PRE, S_REF, S_SRE, S_SR} ddrq_st_type;

	// system domain state
	typedef struct packed {
		ddrq_st_type st;
		ddrq_st_type ret;
		logic [7:0] gap;
		logic tgl;
		logic a1;
		logic a2;
		logic r1;
		logic r2;
		logic r3;
		logic h1;
		logic h2;
		logic h3;
		logic [3:0] hcnt;
		logic [1:0] hidle;
		logic clk_ok;
		ddrq_cmd_type cmd;
		logic [QAW-1:0] head;
		logic [QAW-1:0] tail;
		logic [QAW:0] cnt;
		logic qv;
		logic isw;
		logic rdp;
		logic rdi;
		logic last_cs;
		logic ref_due;
		logic [AAW-1:0] raddr;
		logic [15:0] refc;
		logic [31:0] timing;
		logic [31:0] refcfg;
		logic [31:0] cscfg;
		logic [31:0] ctrl;
		logic [31:0] adv;
		logic wait_n;
		logic [31:0] rdata;
		logic ready;
		logic rsp_v;
		logic [DW-1:0] rsp_d;
		logic [7:0] since_act;
		ddrq_op_type prev_op;
	} ddrq_sys_type;

	// link domain state
	typedef struct packed {
		logic t1;
		logic t2;
		logic t3;
		logic ack;
		logic hb;
		logic act;
		logic adv;
		logic rtgl;
		logic rx_en;
		logic [2:0] rem;
		ddrq_cmd_type pin;
		logic [DW-1:0] rdata;
	} ddrq_lnk_type;

	ddrq_sys_type s_q;
	ddrq_sys_type s_d;
	ddrq_lnk_type m_q;
	ddrq_lnk_type m_d;
	ddrq_ent_type qrd;
	logic push;
	logic pop;
	logic [AAW-1:0] ea;
	logic [7:0] post;
	logic ap_on;
	logic [3:0] atp;
	logic [2:0] atr;
	logic [BTP_W-1:0] btp;
	logic [15:0] rfi;
	logic [1:0] cl;
	logic sr_req;
	logic advon;

	// byte-lane merge of a register write
	function automatic logic [31:0] be_merge(logic [31:0] o, logic [31:0] v, logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				o[8*i +: 8] = v[8*i +: 8];
			end
		end
		return o;
	endfunction

	// early enable only for the value that matches the cas latency
	function automatic logic adv_on(logic [31:0] r, logic [1:0] c);
		return (c == CL_2 && r == ADV_CL2) || (c != CL_2 && r == ADV_CL3); // see (RULE10)
	endfunction

	// hand one command to the link and wait g cycles after its echo
	function automatic ddrq_sys_type go(ddrq_sys_type x, ddrq_op_type op, ddrq_st_type r,
		logic [7:0] g);
		x.prev_op = x.cmd.op;
		x.cmd.op = op;
		x.tgl = ~x.tgl;
		x.st = S_WAIT;
		x.ret = r;
		x.gap = g;
		if (op == OP_ACT) begin
			x.since_act = 8'h00;
		end
		return x;
	endfunction

	// decoded configuration fields
	assign atp = s_q.timing[ATP_LSB +: 4]; // see (RULE5)
	assign atr = s_q.timing[ATR_LSB +: 3]; // see (RULE5)
	assign btp = s_q.refcfg[BTP_LSB +: BTP_W];
	assign rfi = s_q.refcfg[RFI_LSB +: 16];
	assign cl = s_q.ctrl[CL_LSB +: 2];
	assign sr_req = s_q.ctrl[SR_BIT];
	assign advon = adv_on(s_q.adv, cl); // see (RULE8)

	// write queue storage
	ddrq_ram #(.W($bits(ddrq_ent_type)), .D(QD), .AW(QAW)) u_queue (
		.clk_sys(clk_sys),
		.we(push),
		.waddr(s_q.tail),
		.wdata(req.ent),
		.raddr(s_q.head),
		.rdata_q(qrd)
	);

	// system domain next state
	always_comb begin
		s_d = s_q;
		push = 1'b0;
		pop = 1'b0;
		ea = (s_q.qv) ? qrd.addr : s_q.raddr;
		ap_on = (btp == '0) || s_q.cscfg[s_q.cmd.cs]; // see (RULE7)
		post = (atp > {1'b0, atr}) ? 8'(atp - {1'b0, atr}) : 8'h01;
		// synchronisers from the link domain
		s_d.a1 = m_q.ack;
		s_d.a2 = s_q.a1;
		s_d.r1 = m_q.rtgl;
		s_d.r2 = s_q.r1;
		s_d.r3 = s_q.r2;
		s_d.h1 = m_q.hb;
		s_d.h2 = s_q.h1;
		s_d.h3 = s_q.h2;
		s_d.qv = (s_q.cnt != '0);
		s_d.since_act = s_q.since_act + 8'(s_q.since_act != 8'hff);
		// memory clock watch: steady after 15 beats, lost after 4 quiet cycles
		if (s_q.h2 != s_q.h3) begin
			s_d.hidle = 2'h0;
			if (s_q.hcnt != 4'hf) begin
				s_d.hcnt = s_q.hcnt + 4'h1;
			end
		end else if (s_q.hidle == 2'h3) begin
			s_d.hcnt = 4'h0;
		end else begin
			s_d.hidle = s_q.hidle + 2'h1;
		end
		s_d.clk_ok = (s_q.hcnt == 4'hf);
		// register slave: answer one cycle after the request
		if ((avs_read || avs_write) && s_q.wait_n) begin
			s_d.wait_n = 1'b0;
			case (avs_address)
				OFF_TIMING: s_d.rdata = s_q.timing;
				OFF_REFCFG: s_d.rdata = s_q.refcfg;
				OFF_CSCFG: s_d.rdata = s_q.cscfg;
				OFF_CTRL: s_d.rdata = s_q.ctrl;
				OFF_STATUS: s_d.rdata = 32'({s_q.clk_ok, s_q.st == S_SR, s_q.rdp, s_q.cnt});
				OFF_ADV: s_d.rdata = s_q.adv;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end else if ((avs_read || avs_write) && !s_q.wait_n) begin
			s_d.wait_n = 1'b1;
			if (avs_write) begin
				case (avs_address)
					OFF_TIMING: s_d.timing = be_merge(s_q.timing, avs_writedata, avs_byteenable);
					OFF_REFCFG: s_d.refcfg = be_merge(s_q.refcfg, avs_writedata, avs_byteenable);
					OFF_CSCFG: s_d.cscfg = be_merge(s_q.cscfg, avs_writedata, avs_byteenable);
					OFF_CTRL: s_d.ctrl = be_merge(s_q.ctrl, avs_writedata, avs_byteenable);
					OFF_ADV: s_d.adv = be_merge(s_q.adv, avs_writedata, avs_byteenable);
					default: ;
				endcase
			end
		end
		// request port: writes queue up, one read waits in its slot
		if (req_valid && s_q.ready) begin
			if (req.write) begin
				push = 1'b1;
			end else begin
				s_d.rdp = 1'b1;
				s_d.raddr = req.ent.addr;
			end
		end
		// read data back from the link
		s_d.rsp_v = 1'b0;
		if (s_q.r2 != s_q.r3) begin
			s_d.rsp_v = 1'b1;
			s_d.rsp_d = m_q.rdata;
			s_d.rdp = 1'b0;
			s_d.rdi = 1'b0;
		end
		// command sequencer
		unique case (s_q.st)
			S_IDLE: begin
				if (s_q.ref_due) begin
					s_d = go(s_d, OP_PALL, S_REF, 8'(TRP_CYC)); // see (RULE6)
				end else if (sr_req && s_q.cnt == '0 && !s_q.qv && !s_q.rdp) begin
					s_d = go(s_d, OP_PALL, S_SRE, 8'(TRP_CYC)); // see (RULE2)
				end else if (s_q.qv || (s_q.rdp && !s_q.rdi)) begin
					// queued writes first, the read only on an empty queue
					s_d.isw = s_q.qv; // see (RULE1) (RULE3)
					s_d.cmd.cs = ea[CS_BIT];
					s_d.cmd.row = ea[ROW_LSB +: 13];
					s_d.cmd.col = ea[COL_LSB +: 10];
					s_d.cmd.wdata = qrd.data;
					s_d.last_cs = ea[CS_BIT];
					// chip select change pays for the early enable
					s_d = go(s_d, OP_ACT, S_RW, 8'(atr) + ((advon && ea[CS_BIT] != s_q.last_cs) ?
						8'(ADV_CYC) : 8'h00)); // see (RULE5) (RULE9)
				end
			end
			S_WAIT: begin
				if (s_q.a2 == s_q.tgl) begin
					if (s_q.gap <= 8'h01) begin
						s_d.st = s_q.ret;
					end else begin
						s_d.gap = s_q.gap - 8'h01;
					end
				end
			end
			S_RW: begin
				s_d.cmd.ap = ap_on; // see (RULE7)
				s_d.cmd.adv = advon; // see (RULE11)
				s_d.cmd.cl = cl;
				// row precharge time follows the auto-precharge point, or the precharge-all from S_PRE when auto-precharge is off
				if (s_q.isw) begin
					pop = 1'b1;
					s_d = go(s_d, OP_WR, ap_on ? S_IDLE : S_PRE,
						ap_on ? post + 8'(TRP_CYC) : post); // see (RULE6)
				end else begin
					s_d.rdi = 1'b1;
					s_d = go(s_d, OP_RD, ap_on ? S_IDLE : S_PRE,
						ap_on ? post + 8'(TRP_CYC) : post); // see (RULE5) (RULE6)
				end
			end
			S_PRE: begin
				s_d = go(s_d, OP_PALL, S_IDLE, 8'(TRP_CYC));
			end
			S_REF: begin
				s_d.ref_due = 1'b0;
				s_d = go(s_d, OP_REF, S_IDLE, 8'(TRFC_CYC)); // see (RULE6)
			end
			S_SRE: begin
				// work that slipped in during the precharge is drained first
				if (s_q.cnt != '0 || s_q.rdp || (req_valid && s_q.ready)) begin
					s_d.st = S_IDLE; // see (RULE2)
				end else begin
					s_d.cmd.cke = 1'b0;
					s_d = go(s_d, OP_SRE, S_SR, 8'h01); // see (RULE2)
				end
			end
			S_SR: begin
				// leave only once the forwarded clock is back and steady
				if (!sr_req && s_q.clk_ok) begin
					s_d.cmd.cke = 1'b1;
					s_d = go(s_d, OP_SRX, S_IDLE, 8'(TXSR_CYC)); // see (RULE4)
				end
			end
		endcase
		// refresh timer, halted in self-refresh; its set wins over the clear
		if (rfi != 16'h0000 && s_q.st != S_SR) begin
			s_d.refc = s_q.refc + 16'h0001;
			if (s_q.refc >= rfi) begin
				s_d.refc = 16'h0000;
				s_d.ref_due = 1'b1;
			end
		end
		// queue pointers and flow control
		s_d.tail = s_q.tail + QAW'(push);
		s_d.head = s_q.head + QAW'(pop);
		s_d.cnt = s_q.cnt + (QAW + 1)'(push) - (QAW + 1)'(pop);
		s_d.ready = (s_d.cnt < (QAW + 1)'(QD)) && !s_d.rdp;
	end

	// system domain register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.wait_n <= 1'b1;
			s_q.cmd.cke <= 1'b1;
			s_q.timing <= TIMING_RST;
			s_q.refcfg <= REFCFG_RST;
			s_q.cscfg <= CSCFG_RST;
			s_q.ctrl <= CTRL_RST;
			s_q.adv <= ADV_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// link domain: command toggle, heartbeat, read capture
	always_comb begin
		m_d = m_q;
		m_d.t1 = s_q.tgl;
		m_d.t2 = m_q.t1;
		m_d.t3 = m_q.t2;
		m_d.hb = ~m_q.hb;
		m_d.pin.op = OP_NOP;
		// command word is stable while its toggle is in flight
		if (m_q.t2 != m_q.t3) begin
			m_d.pin = s_q.cmd;
			m_d.ack = m_q.t2;
			if (s_q.cmd.op == OP_RD) begin
				m_d.act = 1'b1;
				m_d.adv = s_q.cmd.adv;
				m_d.rem = (s_q.cmd.cl == CL_2) ? 3'd2 : 3'd3;
			end
		end
		// capture data at the cas latency
		if (m_q.act) begin
			if (m_q.rem == 3'd0) begin
				m_d.act = 1'b0;
				m_d.rdata = mem_dq_i;
				m_d.rtgl = ~m_q.rtgl;
			end else begin
				m_d.rem = m_q.rem - 3'd1;
			end
		end
		// receivers open with the data, or two cycles ahead with the advance
		m_d.rx_en = m_d.act && (m_d.rem <= (m_d.adv ? 3'(ADV_CYC) : 3'd0)); // see (RULE8)
	end

	// link domain register
	always_ff @(posedge forwarded_memory_clock or negedge rstn) begin
		if (!rstn) begin
			m_q <= '0;
			m_q.pin.cke <= 1'b1;
		end else begin
			m_q <= m_d;
		end
	end

	// outputs straight from registers
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_n;
	assign req_ready = s_q.ready;
	assign rsp_valid = s_q.rsp_v;
	assign rsp_rdata = s_q.rsp_d;
	assign mem_cmd = m_q.pin;
	assign mem_rx_en = m_q.rx_en;

	// a command leaves the sequencer
	sequence issue_s(ddrq_op_type o);
		$changed(s_q.tgl) && s_q.cmd.op == o;
	endsequence

	sequence rw_s;
		$changed(s_q.tgl) && s_q.cmd.op inside {OP_RD, OP_WR};
	endsequence

	rd_drain_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE1)
		issue_s(OP_RD) |-> s_q.cnt == '0)
		else $error("read issued with writes still queued");

	sr_empty_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE2)
		issue_s(OP_SRE) |-> s_q.cnt == '0 && !s_q.rdp)
		else $error("self-refresh entered with work pending");

	queue_resume_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE3)
		s_q.st == S_IDLE && s_q.qv && !s_q.ref_due |=> issue_s(OP_ACT))
		else $error("queued write not started from idle");

	srx_clock_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE4)
		issue_s(OP_SRX) |-> s_q.clk_ok && $past(s_q.clk_ok))
		else $error("self-refresh exit without steady memory clock");

	act_spacing_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE5)
		rw_s |-> s_q.since_act > 8'(atr))
		else $error("read or write too soon after activate");

	ref_prep_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE6)
		issue_s(OP_REF) |-> s_q.prev_op == OP_PALL)
		else $error("refresh without precharge-all before it");

	ap_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE7)
		rw_s and (btp != '0 && !s_q.cscfg[s_q.cmd.cs]) |-> !s_q.cmd.ap)
		else $error("auto-precharge used while disabled");

	rx_early_a: assert property (@(posedge forwarded_memory_clock) disable iff (!rstn) // see (RULE8)
		$changed(m_q.rtgl) |-> $past(m_q.rx_en, 3) == m_q.adv)
		else $error("receiver enable lead does not match advance");

	cs_same_gap_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see (RULE9)
		$changed(s_q.tgl) && s_q.cmd.op == OP_ACT && s_q.last_cs == $past(s_q.last_cs)
		|-> s_q.gap == 8'(atr))
		else $error("chip select switch cost charged on one chip select");
endmodule

// File: logic/ddrq_pkg.sv
// constants, field layout and carrier types of the ddr queue and timing block
// assumes a 50 MHz system clock and byte addresses on the register bus
package ddrq_pkg;
	// register byte offsets
	localparam logic [15:0] OFF_TIMING = 16'h0000;
	localparam logic [15:0] OFF_REFCFG = 16'h0004;
	localparam logic [15:0] OFF_CSCFG = 16'h0008;
	localparam logic [15:0] OFF_CTRL = 16'h000c;
	localparam logic [15:0] OFF_STATUS = 16'h0010;
	localparam logic [15:0] OFF_ADV = 16'h2f00;
	// field positions, msb-0 bits 4:7 and 9:11 of the timing word
	localparam int ATP_LSB = 24;
	localparam int ATR_LSB = 20;
	localparam int BTP_LSB = 0;
	localparam int BTP_W = 14;
	localparam int RFI_LSB = 16;
	localparam int CL_LSB = 0;
	localparam int SR_BIT = 2;
	// request address layout
	localparam int CS_BIT = 23;
	localparam int ROW_LSB = 10;
	localparam int COL_LSB = 0;
	// reset values
	localparam logic [31:0] TIMING_RST = 32'h0000_0000;
	localparam logic [31:0] REFCFG_RST = 32'h0000_0000;
	localparam logic [31:0] CSCFG_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ADV_RST = 32'h0000_0000;
	// accepted values of the receiver enable advance register
	localparam logic [31:0] ADV_CL2 = 32'h201c_0000;
	localparam logic [31:0] ADV_CL3 = 32'h202c_0000;
	// cas latency codes
	localparam logic [1:0] CL_2 = 2'h0;
	localparam logic [1:0] CL_25 = 2'h1;
	localparam logic [1:0] CL_3 = 2'h2;
	// timing, in ns, and cycle counts at the system clock rate
	localparam int CLK_MHZ = 50;
	localparam int T_RP_NS = 20;
	localparam int T_RFC_NS = 80;
	localparam int T_XSR_NS = 200;
	localparam int TRP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int TRFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
	localparam int TXSR_CYC = (T_XSR_NS * CLK_MHZ + 999) / 1000;
	localparam int ADV_CYC = 2;
	// widths
	localparam int AAW = 24;
	localparam int DW = 32;

	typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PALL, OP_REF, OP_SRE, OP_SRX}
		ddrq_op_type;

	// one queued write or read address
	typedef struct packed {
		logic [AAW-1:0] addr;
		logic [DW-1:0] data;
	} ddrq_ent_type;

	// system side request
	typedef struct packed {
		logic write;
		ddrq_ent_type ent;
	} ddrq_req_type;

	// command word handed to the memory pins
	typedef struct packed {
		ddrq_op_type op;
		logic cs;
		logic ap;
		logic adv;
		logic [1:0] cl;
		logic cke;
		logic [12:0] row;
		logic [9:0] col;
		logic [DW-1:0] wdata;
	} ddrq_cmd_type;
endpackage

// File: logic/ddrq_ram.sv
// storage of the write queue
// assumes one write port and one read port, both on the system clock
`timescale 1ns/10ps
module ddrq_ram #(
	parameter int W = 56,
	parameter int D = 8,
	parameter int AW = 3
) (
	input wire logic clk_sys, // system clock
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write slot
	input wire logic [W-1:0] wdata, // write word
	input wire logic [AW-1:0] raddr, // read slot
	output logic [W-1:0] rdata_q // registered read word
);
	logic [W-1:0] mem [D];

	// write on strobe, read every cycle into a register
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule

// File: verification/ddrq_mem_model.sv
// behavioural ddr memory behind the command pins
// assumes one registered command per link cycle, data sampled lat+1 edges after op
`timescale 1ns/10ps
module ddrq_mem_model (
	input wire logic fclk, // link clock
	input wire ddrq_pkg::ddrq_cmd_type cmd, // command pins
	output logic [ddrq_pkg::DW-1:0] dq // read data to controller
);
	import ddrq_pkg::*;
	logic [DW-1:0] mem [logic [23:0]];
	logic [DW-1:0] rd_q;
	int cnt;
	initial begin
		dq = '0;
		cnt = 0;
	end
	// store writes; drive read data for one cycle, else a toggling pattern
	always @(posedge fclk) begin
		if (cmd.op == OP_WR) begin
			mem[{cmd.cs, cmd.row, cmd.col}] = cmd.wdata;
		end
		if (cmd.op == OP_RD) begin
			rd_q <= mem.exists({cmd.cs, cmd.row, cmd.col}) ? mem[{cmd.cs, cmd.row, cmd.col}] : ~dq;
			cnt <= (cmd.cl == CL_2) ? 1 : 2;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
		dq <= (cnt == 1) ? rd_q : ~dq;
	end
endmodule

// File: verification/tb_ddr_sdram_queue_and_timing.sv
// self-checking bench of the ddr queue and timing controller
// assumes the memory model on the command pins and avalon registers on clk_sys
`timescale 1ns/10ps
module tb_ddr_sdram_queue_and_timing;
	import ddrq_pkg::*;
	logic clk_sys, rstn, fclk, fstop, noap;
	logic [15:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, req_valid, req_ready, rsp_valid, mem_rx_en;
	logic [31:0] avs_writedata, avs_readdata, rsp_rdata, mem_dq_i, rd;
	logic [3:0] avs_byteenable;
	ddrq_req_type req;
	ddrq_cmd_type mem_cmd;
	ddrq_op_type last_op;
	logic [31:0] exp_mem [logic [23:0]];
	logic [23:0] a;
	logic [15:0] offs [6] = '{OFF_TIMING, OFF_REFCFG, OFF_CSCFG, OFF_CTRL, OFF_ADV, 16'h0100};
	logic [1:0] cls [5] = '{CL_2, CL_2, CL_25, CL_3, CL_3};
	logic [31:0] advs [5] = '{ADV_CL2, ADV_CL3, ADV_CL3, ADV_CL3, ADV_CL2};
	int ext [5] = '{ADV_CYC, 0, ADV_CYC, ADV_CYC, 0};
	int n_mismatch, tests_run, rxc, n_ref, base, i, j;

	// controller under test
	ddrq_ctrl #(.QD(8), .QAW(3)) dut (.clk_sys(clk_sys), .rstn(rstn),
		.forwarded_memory_clock(fclk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.mem_cmd(mem_cmd), .mem_rx_en(mem_rx_en), .mem_dq_i(mem_dq_i));
	ddrq_mem_model mem (.fclk(fclk), .cmd(mem_cmd), .dq(mem_dq_i));

	// system clock, 20 ns
	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	// link clock, 30 ns, own phase, stoppable
	initial begin
		fclk = 0;
		#7;
		forever begin
			#15;
			if (!fstop) fclk = ~fclk;
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task fail;
		n_mismatch++;
		end_of_test();
	endtask

	// avalon access held until waitrequest is sampled low
	task bus(input logic wr, input logic [15:0] adr, input logic [31:0] wd, output logic [31:0] d);
		int k;
		@(posedge clk_sys);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		d = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (avs_waitrequest !== 1'b0) fail();
	endtask

	// one request held until taken; a read waits for its data
	task send(input logic wr, input logic [23:0] adr, input logic [31:0] wd);
		int k;
		@(posedge clk_sys);
		req_valid <= 1;
		req <= {wr, adr, wd};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (req_ready !== 1'b1 && k < 500);
		req_valid <= 0;
		if (req_ready !== 1'b1) fail();
		if (wr) begin
			exp_mem[adr] = wd;
		end else begin
			k = 0;
			do begin
				@(posedge clk_sys);
				k++;
			end while (rsp_valid !== 1'b1 && k < 3000);
			if (rsp_valid !== 1'b1) fail();
			check(rsp_rdata, exp_mem[adr]);
		end
	endtask

	// link-side watch of command order, auto-precharge and receiver enable
	always @(posedge fclk) begin
		if (mem_rx_en === 1'b1) rxc++;
		if (mem_cmd.op == OP_REF) begin
			n_ref++;
			check(32'(last_op), 32'(OP_PALL));
		end
		if (mem_cmd.op == OP_RD || mem_cmd.op == OP_WR) begin
			check(32'(mem_cmd.ap), 32'(!noap));
		end
		if (mem_cmd.op != OP_NOP) last_op = mem_cmd.op;
	end

	// main sequence
	initial begin
		void'($urandom(73));
		{rstn, fstop, noap, avs_read, avs_write, req_valid} = '0;
		{avs_address, avs_writedata, req} = '0;
		avs_byteenable = 4'hf;
		{n_mismatch, tests_run, rxc, n_ref} = '0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1;
		repeat (2) @(posedge clk_sys);
		// reset values, unmapped place ignores writes
		bus(1, 16'h0100, 32'hffff_ffff, rd);
		for (i = 0; i < 6; i++) begin
			bus(0, offs[i], 0, rd);
			check(rd, 0);
		end
		// only the enabled byte lane of a write lands
		avs_byteenable <= 4'h1;
		bus(1, OFF_CSCFG, 32'hffff_ffff, rd);
		avs_byteenable <= 4'hf;
		bus(0, OFF_CSCFG, 0, rd);
		check(rd, 32'h0000_00ff);
		// activate spacing above rw spacing plus two
		bus(1, OFF_TIMING, 32'h0630_0000, rd);
		bus(0, OFF_TIMING, 0, rd);
		check(rd, 32'h0630_0000);
		// refresh on, burst field non-zero, auto-precharge enables clear
		bus(1, OFF_REFCFG, {16'h0040, 16'h0004}, rd);
		bus(1, OFF_CSCFG, 0, rd);
		noap = 1;
		// random traffic, reads colliding with queued writes
		for (i = 0; i < 40; i++) begin
			a = {1'($urandom), 11'h0, 2'($urandom), 8'h0, 2'($urandom)};
			if (!exp_mem.exists(a) || $urandom_range(1) == 1) send(1, a, $urandom);
			else send(0, a, 0);
		end
		// self-refresh requested with writes still queued
		for (j = 0; j < 4; j++) send(1, 24'(j * 1025), $urandom);
		bus(1, OFF_CTRL, 32'h4, rd);
		j = 0;
		do begin
			bus(0, OFF_STATUS, 0, rd);
			j++;
		end while (rd[5] !== 1'b1 && j < 200);
		if (rd[5] !== 1'b1) fail();
		check(32'(rd[3:0]), 0);
		fstop = 1;
		repeat (20) @(posedge clk_sys);
		// writes taken while asleep must run once the memory is back
		for (j = 0; j < 4; j++) send(1, 24'(j * 1025), $urandom);
		bus(1, OFF_CTRL, 0, rd);
		bus(0, OFF_STATUS, 0, rd);
		check(32'(rd[6]), 0);
		check(32'(rd[5]), 1);
		fstop = 0;
		j = 0;
		do begin
			bus(0, OFF_STATUS, 0, rd);
			j++;
		end while (rd[5] !== 1'b0 && j < 200);
		if (rd[5] !== 1'b0) fail();
		for (j = 0; j < 4; j++) send(0, 24'(j * 1025), 0);
		// receiver enable advance per cas latency, new value from next read
		for (i = 0; i < 5; i++) begin
			bus(1, OFF_ADV, 0, rd);
			bus(1, OFF_CTRL, {30'h0, cls[i]}, rd);
			rxc = 0;
			send(0, a, 0);
			base = rxc;
			bus(1, OFF_ADV, advs[i], rd);
			bus(0, OFF_ADV, 0, rd);
			check(rd, advs[i]);
			rxc = 0;
			send(0, a, 0);
			check(32'(rxc - base), 32'(ext[i]));
		end
		// auto-precharge back on through the chip select enables
		bus(1, OFF_CSCFG, 32'h3, rd);
		noap = 0;
		send(1, a, $urandom);
		send(0, a, 0);
		check(32'(n_ref != 0), 1);
		end_of_test();
	end
endmodule
